// ### dv/ccx_exec_asserts.sv
// Purpose: Ties executer outputs to the words that cause them.
// Assumes: Bound into ccx_exec; sees its ports only.
// Notes:   Two helper registers keep the last instruction words.
`timescale 1ns/100ps
module ccx_exec_asserts
  import ccx_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        reset_n_i,
  input wire logic [15:0] instr_i,
  input wire logic [7:0]  file_rdata_i,
  input wire ccx_fwr_t    file_wr_o,
  input wire logic [20:0] pc_o,
  input wire logic        flush_o,
  input wire logic        stack_push_o,
  input wire logic [20:0] stack_data_o,
  input wire logic        wdt_clear_o,
  input wire logic [7:0]  accum_o,
  input wire ccx_flags_t  flags_o,
  input wire logic [7:0]  accumulator_shadow_o,
  input wire logic        watchdog_expiry_flag_o,
  input wire logic        sleep_entry_flag_o
);
  logic [15:0] w0_r;
  logic [15:0] w1_r;
  wire         run_w = !flush_o;
  // Word history for the call target and the branch offset.
  always_ff @(posedge mclk_i)
  begin
    w0_r <= instr_i;
    w1_r <= w0_r;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  push_data_a:
    assert property (stack_push_o |-> stack_data_o == pc_o + 21'h4)
      else $error("push data");
  call_flush_a:
    assert property (stack_push_o |=> flush_o ##1 !flush_o)
      else $error("call length");
  call_target_a:
    assert property (stack_push_o ##1 instr_i[15:12] == 4'hf
      |=> pc_o == {w0_r[11:0], w1_r[7:0], 1'b0}) else $error("call pc");
  shadow_save_a:
    assert property (stack_push_o && instr_i[8]
      |=> accumulator_shadow_o == $past(accum_o)) else $error("shadow");
  wdt_kick_a:
    assert property (run_w && instr_i == 16'h0004 |-> wdt_clear_o
      ##1 watchdog_expiry_flag_o && sleep_entry_flag_o) else $error("kick");
  file_clear_a:
    assert property (run_w && instr_i[15:9] == 7'h35 |-> file_wr_o.we
      && file_wr_o.data == 8'h00 ##1 flags_o.zero) else $error("clear");
  file_invert_a:
    assert property (run_w && instr_i[15:9] == 7'h0f |-> file_wr_o.we
      && file_wr_o.data == ~file_rdata_i) else $error("invert");
  branch_taken_a:
    assert property (run_w && instr_i[15:8] == 8'he0 && flags_o.zero |=>
      flush_o && pc_o == $past(pc_o) + 21'h2
      + {{12{w0_r[7]}}, w0_r[7:0], 1'b0}) else $error("branch");
  cover property (stack_push_o && instr_i[8]);
  cover property (wdt_clear_o);
  cover property (flush_o && w0_r[15:8] == 8'he0);
endmodule

bind ccx_exec ccx_exec_asserts u_chk (.*);

// ### dv/ccx_file_model.sv
// Purpose: File register store facing the executer.
// Assumes: Reads answer the address at once; writes land at the edge.
// Notes:   Byte i starts as its low address byte xor 3c.
`timescale 1ns/100ps
module ccx_file_model
  import ccx_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic [11:0] file_addr_i,
  input  wire ccx_fwr_t    file_wr_i,
  output logic [7:0]       file_rdata_o
);
  logic [7:0] mem [0:4095];
  // Known contents so expected values can be worked out.
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i) ^ 8'h3c;
  end
  // Read is combinational; a write changes the byte at the edge.
  assign file_rdata_o = mem[file_addr_i];
  always @(posedge mclk_i)
  begin
    if (file_wr_i.we)
      mem[file_wr_i.addr] <= file_wr_i.data;
  end
endmodule

// ### dv/tb_ccx_exec.sv
// Purpose: Directed run of call, clear, invert, kick and branch words.
// Assumes: The file model answers its address within the cycle.
// Notes:   The variable p follows the program counter of the current word.
`timescale 1ns/100ps
module tb_ccx_exec
  import ccx_pkg::*;
;
  logic        mclk_i;
  logic        reset_n_i;
  logic [15:0] instr_i;
  logic        ext_set_en_i;
  logic [11:0] index_base_i;
  logic [7:0]  file_rdata_i;
  logic [11:0] file_addr_o;
  ccx_fwr_t    file_wr_o;
  logic [20:0] pc_o;
  logic        flush_o;
  logic        stack_push_o;
  logic [20:0] stack_data_o;
  logic        wdt_clear_o;
  logic [7:0]  accum_o;
  ccx_flags_t  flags_o;
  logic [3:0]  bank_select_o;
  ccx_flags_t  flags_shadow_o;
  logic [3:0]  bank_shadow_o;
  logic [7:0]  accumulator_shadow_o;
  logic        watchdog_expiry_flag_o;
  logic        sleep_entry_flag_o;
  logic [20:0] p;
  int          errors;
  int          compares;
  ccx_exec DUT (.*);
  ccx_file_model u_mem (.mclk_i, .file_addr_i(file_addr_o),
    .file_wr_i(file_wr_o), .file_rdata_o(file_rdata_i));
  // Free-running clock of 10 ns.
  always #5 mclk_i = ~mclk_i;
  // Compare one value and count it.
  task automatic chk(input string n, input logic [20:0] e,
    input logic [20:0] g);
    compares++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      errors++;
    end
  endtask
  // Present one word after the edge and let outputs settle.
  task automatic step(input logic [15:0] w);
    @(posedge mclk_i);
    instr_i <= w;
    #1;
    p = p + 21'h2;
  endtask
  // Print the verdict and stop.
  task automatic final_report;
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence of words and expected values.
  initial
  begin
    mclk_i = 1'b0;
    reset_n_i = 1'b0;
    instr_i = 16'h0000;
    ext_set_en_i = 1'b0;
    index_base_i = 12'h000;
    errors = 0;
    compares = 0;
    p = 21'h000000;
    repeat (3) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    step(16'h0004);
    chk("kick", 21'h1, 21'(wdt_clear_o));
    step(16'h6a10);
    chk("clr", 21'h101000, file_wr_o);
    chk("wto", 21'h1, 21'(watchdog_expiry_flag_o));
    chk("slp", 21'h1, 21'(sleep_entry_flag_o));
    step(16'h6a80);
    chk("clr", 21'h1f8000, file_wr_o);
    chk("flg", 21'h4, 21'(flags_o));
    step(16'h6b22);
    chk("clr", 21'h102200, file_wr_o);
    chk("bsel", 21'h0, 21'(bank_select_o));
    step(16'h1e05);
    chk("inv", 21'h1005c6, file_wr_o);
    step(16'h1cc3);
    chk("flg", 21'h10, 21'(flags_o));
    chk("we", 21'h0, 21'(file_wr_o.we));
    step(16'h1c05);
    chk("acc", 21'h0, 21'(accum_o));
    chk("flg", 21'h4, 21'(flags_o));
    step(16'h1c06);
    chk("acc", 21'h39, 21'(accum_o));
    step(16'hed34);
    chk("push", 21'h1, 21'(stack_push_o));
    chk("ret", p + 21'h4, stack_data_o);
    step(16'hfabc);
    chk("fl", 21'h1, 21'(flush_o));
    chk("sh", 21'hc5, 21'(accumulator_shadow_o));
    chk("fsh", 21'h10, 21'(flags_shadow_o));
    chk("bsh", 21'h0, 21'(bank_shadow_o));
    p = 21'h157866;
    step(16'h1c05);
    chk("pc", p, pc_o);
    step(16'hec01);
    step(16'hf000);
    chk("sh", 21'hc5, 21'(accumulator_shadow_o));
    chk("fsh", 21'h10, 21'(flags_shadow_o));
    p = 21'h000000;
    step(16'h1c06);
    chk("pc", p, pc_o);
    step(16'he07f);
    step(16'h6a00);
    chk("fl", 21'h0, 21'(flush_o));
    chk("pc", p, pc_o);
    step(16'he080);
    p = p - 21'h100;
    step(16'h0000);
    chk("fl", 21'h1, 21'(flush_o));
    chk("pc", p, pc_o);
    // Indexed offset mode at its top address, then just above it.
    @(posedge mclk_i);
    ext_set_en_i <= 1'b1;
    index_base_i <= 12'h300;
    step(16'h6a5f);
    chk("idx", 21'h135f00, file_wr_o);
    step(16'h6a60);
    chk("idx", 21'h1f6000, file_wr_o);
    step(16'h6b10);
    chk("idx", 21'h101000, file_wr_o);
    final_report();
  end
endmodule

// ### rtl/ccx_defs.svh
// Purpose: Constants for the call, clear, invert and watchdog-kick executer.
// Assumes: 16-bit instruction words, 21-bit byte program counter.
// Notes:   Opcode patterns are matched against the upper instruction bits; the kick against the whole word.
`ifndef CCX_DEFS_SVH
`define CCX_DEFS_SVH

// ---------------------------------------------------------------------------
// Opcode patterns
// ---------------------------------------------------------------------------
`define CCX_OP_BRZ_HI    8'he0
`define CCX_OP_CALL_HI   7'h76
`define CCX_OP_CALL2_HI  4'hf
`define CCX_OP_CLR_HI    7'h35
`define CCX_OP_INV_HI    6'h07
`define CCX_OP_KICK      16'h0004

// ---------------------------------------------------------------------------
// Addressing and reset values
// ---------------------------------------------------------------------------
`define CCX_IDX_LIMIT    8'h5f
`define CCX_ACC_SPLIT    8'h60
`define CCX_ACC_HI_BANK  4'hf
`define CCX_PC_RST       21'h000000
`define CCX_PC_STEP      21'h000002
`define CCX_RET_OFS      21'h000004

`endif

// ### rtl/ccx_exec.sv
// Purpose: Executes branch_on_zero_flag, subroutine call, file_clear,
//          watchdog_kick and file_invert; one word per instruction cycle.
// Assumes: instr_i is the fetched word of the cycle; file_rdata_i answers
//          file_addr_o combinationally.
// Notes:   Words that match no pattern here execute as plain steps.
// Summary of operation
// - A zero-flag branch adds 2n+2 and adds one idle cycle if taken.
// - The call reaches any target of the 2 Mbyte space absolutely.
// - The call pushes the address four bytes past itself.
// - The call copies W, flags and bank when its save bit is set.
// - The call loads its 20-bit literal into PC bits 20 to 1.
// - The call takes two cycles, the second an idle fetch.
// - Access bit 0 picks the access bank, 1 takes the bank register.
// - Access bit 0 with extended set and f <= 95 uses indexed offset.
// - The watchdog kick clears counter and postscaler, sets two flags.
// - File invert forms the inverse and updates negative and zero.
// - File invert with d 0 writes the accumulator only.
// - File invert with d 1 writes back the file register.
`timescale 1ns/100ps
`include "ccx_defs.svh"

module ccx_exec
  import ccx_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        ext_set_en_i,
  input  wire logic [11:0] index_base_i,
  input  wire logic [7:0]  file_rdata_i,
  output logic [11:0]      file_addr_o,
  output ccx_fwr_t         file_wr_o,
  output logic [20:0]      pc_o,
  output logic             flush_o,
  output logic             stack_push_o,
  output logic [20:0]      stack_data_o,
  output logic             wdt_clear_o,
  output logic [7:0]       accum_o,
  output ccx_flags_t       flags_o,
  output logic [3:0]       bank_select_o,
  output logic [7:0]       accumulator_shadow_o,
  output ccx_flags_t       flags_shadow_o,
  output logic [3:0]       bank_shadow_o,
  output logic             watchdog_expiry_flag_o,
  output logic             sleep_entry_flag_o
);

  // -------------------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------------------
  // Zero test used by invert and clear.
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  ccx_state_t  state_r;
  ccx_state_t  state_nxt;
  logic [20:0] pc_r;
  logic [20:0] pc_nxt;
  logic [7:0]  call_lo_r;
  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  ccx_flags_t  flg_r;
  ccx_flags_t  flg_nxt;
  logic [3:0]  bank_r;
  logic [7:0]  acc_sh_r;
  ccx_flags_t  flg_sh_r;
  logic [3:0]  bank_sh_r;
  logic        wdto_r;
  logic        slp_r;

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  // Opcode matches are only valid in the execute state.
  wire         in_exec  = (state_r == CCX_ST_EXEC);
  wire         dec_brz  = in_exec && (instr_i[15:8] == `CCX_OP_BRZ_HI);
  wire         dec_call = in_exec && (instr_i[15:9] == `CCX_OP_CALL_HI);
  wire         dec_clr  = in_exec && (instr_i[15:9] == `CCX_OP_CLR_HI);
  wire         dec_inv  = in_exec && (instr_i[15:10] == `CCX_OP_INV_HI);
  wire         dec_kick = in_exec && (instr_i == `CCX_OP_KICK);
  wire         fld_a    = instr_i[8];
  wire         fld_d    = instr_i[9];
  wire [7:0]   fld_f    = instr_i[7:0];
  wire         brz_take = dec_brz && flg_r.zero;
  wire         call2_ok = (instr_i[15:12] == `CCX_OP_CALL2_HI);

  // Effective file address.
  // indexed offset mode
  wire         idx_mode = !fld_a && ext_set_en_i && (fld_f <= `CCX_IDX_LIMIT);
  wire [11:0]  idx_addr = index_base_i + {4'h0, fld_f};
  wire [11:0]  acc_addr = (fld_f < `CCX_ACC_SPLIT) ? {4'h0, fld_f}
                                                   : {`CCX_ACC_HI_BANK, fld_f};
  wire [11:0]  bnk_addr = {bank_r, fld_f};
  assign file_addr_o = idx_mode ? idx_addr : (fld_a ? bnk_addr : acc_addr);

  wire [7:0]   inv_val  = ~file_rdata_i;

  // Branch target, 2n sign extended.
  // offset arithmetic
  wire [20:0]  brz_ofs  = {{12{instr_i[7]}}, instr_i[7:0], 1'b0};
  wire [20:0]  pc_inc   = pc_r + `CCX_PC_STEP;

  // -------------------------------------------------------------------------
  // Next-state logic
  // -------------------------------------------------------------------------
  // Sequencing, program counter, accumulator and flags.
  always_comb
  begin
    state_nxt = CCX_ST_EXEC;
    pc_nxt    = pc_inc;
    acc_nxt   = acc_r;
    flg_nxt   = flg_r;
    case (state_r)
      CCX_ST_EXEC:
      begin
        if (brz_take)
        begin
          pc_nxt    = pc_inc + brz_ofs;
          state_nxt = CCX_ST_FLUSH;
        end
        if (dec_call)
          state_nxt = CCX_ST_CALL2;
        if (dec_inv)
        begin
          flg_nxt.neg  = inv_val[7];
          flg_nxt.zero = is_zero(inv_val);
          if (!fld_d)
            acc_nxt = inv_val;
        end
        if (dec_clr)
          flg_nxt.zero = is_zero(8'h00);
      end
      CCX_ST_CALL2:
      begin
        pc_nxt = {instr_i[11:0], call_lo_r, 1'b0};
        if (!call2_ok)
          pc_nxt = pc_inc;
      end
      CCX_ST_FLUSH:
        pc_nxt = pc_r;
      default:
        state_nxt = CCX_ST_EXEC;
    endcase
  end

  // File register write port.
  // write back to file
  assign file_wr_o.we   = dec_clr || (dec_inv && fld_d);
  assign file_wr_o.addr = file_addr_o;
  assign file_wr_o.data = dec_clr ? 8'h00 : inv_val;

  // Return stack push of PC+4 during the call's first cycle.
  // push return address
  assign stack_push_o = dec_call;
  assign stack_data_o = pc_r + `CCX_RET_OFS;

  // Watchdog counter and postscaler clear.
  // watchdog clear
  assign wdt_clear_o = dec_kick;
  assign flush_o     = (state_r != CCX_ST_EXEC);

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  // Core sequencing registers.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      state_r     <= CCX_ST_EXEC;
      pc_r        <= `CCX_PC_RST;
      acc_r       <= 8'h00;
      flg_r       <= '0;
      call_lo_r   <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      acc_r   <= acc_nxt;
      flg_r   <= flg_nxt;
      if (dec_call)
        call_lo_r <= instr_i[7:0];
    end
  end

  // Shadow registers and bank select.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      bank_r    <= 4'h0;
      acc_sh_r  <= 8'h00;
      flg_sh_r  <= '0;
      bank_sh_r <= 4'h0;
    end
    else if (dec_call && instr_i[8])
    begin
      acc_sh_r  <= acc_r;
      flg_sh_r  <= flg_r;
      bank_sh_r <= bank_r;
    end
  end

  // Watchdog status flags, active-low meaning kept by the core.
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      wdto_r <= 1'b1;
      slp_r  <= 1'b1;
    end
    else if (dec_kick)
    begin
      wdto_r <= 1'b1;
      slp_r  <= 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign pc_o                   = pc_r;
  assign accum_o                = acc_r;
  assign flags_o                = flg_r;
  assign bank_select_o          = bank_r;
  assign accumulator_shadow_o   = acc_sh_r;
  assign flags_shadow_o         = flg_sh_r;
  assign bank_shadow_o          = bank_sh_r;
  assign watchdog_expiry_flag_o = wdto_r;
  assign sleep_entry_flag_o     = slp_r;

endmodule

// ### rtl/ccx_pkg.sv
// Purpose: Types for the call, clear, invert and watchdog-kick executer.
// Assumes: Constants come from ccx_defs.svh.
// Notes:   Status flags are packed into one struct.
package ccx_pkg;

  // Core status flags.
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dc;
    logic carry;
  } ccx_flags_t;

  // File register write request.
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } ccx_fwr_t;

  // Execution state.
  typedef enum logic [1:0] {
    CCX_ST_EXEC,
    CCX_ST_CALL2,
    CCX_ST_FLUSH
  } ccx_state_t;

endpackage
